// file: pts_pkg.sv
// constants for the system time seconds register block
package pts_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h0700;
    localparam logic [11:0] OFF_INCR = 12'h0704;
    localparam logic [11:0] OFF_SEC_NOW = 12'h0708;
    localparam logic [11:0] OFF_SUB_NOW = 12'h070C;
    localparam logic [11:0] OFF_SEC_LOAD = 12'h0710;
    localparam logic [11:0] OFF_SUB_LOAD = 12'h0714;
    localparam logic [11:0] OFF_ADDEND = 12'h0718;
    localparam int BIT_FINE = 1;
    localparam int BIT_INIT = 2;
    localparam int BIT_ADJUST = 3;
    localparam int BIT_DECIMAL = 9;
    localparam int BIT_ADD_SUBTRACT_SELECT = 31;
    localparam int SUB_W = 31;
    localparam int INC_W = 8;
    localparam logic [31:0] BIN_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] DEC_MAX = 32'h3B9A_C9FF;
    localparam logic [31:0] BIN_LIMIT = BIN_MAX + 32'h0000_0001;
    localparam logic [31:0] DEC_LIMIT = DEC_MAX + 32'h0000_0001;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 8;
endpackage

// file: pts_time_counter.sv
// seconds and sub-seconds counter with init, update and rollover
`timescale 1ns/10ps
module pts_time_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fine_coarse_select,
    input wire logic decimal_rollover_select,
    input wire logic time_init_bit,
    input wire logic time_adjust_bit,
    input wire logic add_subtract_select,
    input wire logic [pts_pkg::INC_W-1:0] subsecond_increment,
    input wire logic [31:0] addend,
    input wire logic [31:0] seconds_load,
    input wire logic [pts_pkg::SUB_W-1:0] subseconds_load,
    output logic [31:0] seconds_field,
    output logic [pts_pkg::SUB_W-1:0] subseconds_field
);
    import pts_pkg::*;

    typedef struct packed {
        logic [31:0] sec;
        logic [SUB_W-1:0] sub;
        logic [31:0] acc;
    } pts_cnt_t;

    pts_cnt_t st_reg;
    pts_cnt_t st_next;
    logic [31:0] limit;
    logic [32:0] acc_sum;
    logic tick;
    logic [31:0] inc_sum;
    logic [31:0] add_sum;
    logic [31:0] sub_diff;
    logic carry;
    logic borrow;

    always_comb begin
        st_next = st_reg;
        // rollover point chosen by the decimal select
        limit = decimal_rollover_select ? DEC_LIMIT : BIN_LIMIT; // see R4 see R7
        acc_sum = {1'b0, st_reg.acc} + {1'b0, addend};
        // coarse steps every cycle, fine steps on accumulator overflow
        tick = fine_coarse_select ? acc_sum[32] : 1'b1; // see R8
        inc_sum = {1'b0, st_reg.sub} + {24'h00_0000, subsecond_increment};
        add_sum = {1'b0, st_reg.sub} + {1'b0, subseconds_load};
        sub_diff = {1'b0, st_reg.sub} - {1'b0, subseconds_load};
        carry = add_sum >= limit;
        borrow = st_reg.sub < subseconds_load;
        if (fine_coarse_select) begin
            st_next.acc = acc_sum[31:0];
        end
        if (time_init_bit) begin
            // overwrite with the load values
            st_next.sec = seconds_load; // see R6
            st_next.sub = subseconds_load;
        end else if (time_adjust_bit) begin
            if (add_subtract_select) begin
                // subtract, borrowing a second on underflow
                st_next.sub = borrow ? SUB_W'(sub_diff + limit)
                                     : SUB_W'(sub_diff); // see R10
                st_next.sec = st_reg.sec - seconds_load
                              - {31'h0000_0000, borrow}; // see R6 see R10
            end else begin
                st_next.sub = carry ? SUB_W'(add_sum - limit)
                                    : SUB_W'(add_sum); // see R10
                st_next.sec = st_reg.sec + seconds_load
                              + {31'h0000_0000, carry}; // see R6 see R10
            end
        end else if (tick) begin
            if (inc_sum >= limit) begin
                st_next.sub = SUB_W'(inc_sum - limit); // see R4 see R7
                st_next.sec = st_reg.sec + 32'h0000_0001; // see R11
            end else begin
                st_next.sub = SUB_W'(inc_sum);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0; // see R1
        end else begin
            st_reg <= st_next;
        end
    end

    assign seconds_field = st_reg.sec;
    assign subseconds_field = st_reg.sub;
endmodule

// file: pts_time_regs.sv
// axi4-lite register block for the system time seconds counters
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
// Contract
// R1 - seconds reads as 32-bit read-only value, zero after reset
// R2 - read values may lag the running counters, which never stop
// R3 - sub-seconds is 31 bits in 30:0, bit 31 reads zero
// R4 - decimal select: 1 ns counts, wraps after 0x3B9A_C9FF
// R5 - software loads both update values before init or update
// R6 - seconds load register is read/write, loaded or added
// R7 - binary mode: sub-seconds wraps after 0x7FFF_FFFF
// R8 - coarse mode adds the increment every reference clock cycle
// R9 - update request clears itself when the update is done
// R10 - add/subtract select chooses subtraction when set
// R11 - sub-seconds rollover adds one second in the same cycle
module pts_time_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pts_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pts_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pts_pkg::*;

    typedef struct packed {
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [INC_W-1:0] incr;
        logic [31:0] addend;
        logic [31:0] sec_load;
        logic [31:0] sub_load;
        logic [31:0] sec_view;
        logic [SUB_W-1:0] sub_view;
    } pts_regs_t;

    pts_regs_t st_reg;
    pts_regs_t st_next;
    logic [31:0] sec_live;
    logic [SUB_W-1:0] sub_live;
    logic do_write;
    logic do_read;
    logic [31:0] wmask;
    logic [31:0] merged;
    logic mapped;

    pts_time_counter pts_time_counter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .fine_coarse_select(st_reg.ctrl[BIT_FINE]),
        .decimal_rollover_select(st_reg.ctrl[BIT_DECIMAL]),
        .time_init_bit(st_reg.ctrl[BIT_INIT]),
        .time_adjust_bit(st_reg.ctrl[BIT_ADJUST]),
        .add_subtract_select(st_reg.sub_load[BIT_ADD_SUBTRACT_SELECT]),
        .subsecond_increment(st_reg.incr),
        .addend(st_reg.addend),
        .seconds_load(st_reg.sec_load),
        .subseconds_load(st_reg.sub_load[SUB_W-1:0]),
        .seconds_field(sec_live),
        .subseconds_field(sub_live)
    );

    assign s_axi_awready = !st_reg.aw_got;
    assign s_axi_wready = !st_reg.w_got;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    always_comb begin
        st_next = st_reg;
        wmask = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}},
                 {8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
        merged = '0;
        mapped = 1'b0;
        // time view passes through one register stage
        st_next.sec_view = sec_live; // see R2
        st_next.sub_view = sub_live; // see R2
        // requests self-clear on the same edge at which the counter acts on them
        st_next.ctrl[BIT_INIT] = 1'b0;
        st_next.ctrl[BIT_ADJUST] = 1'b0; // see R9
        // capture address and data in either order
        if (s_axi_awvalid && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        do_write = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        if (do_write) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            case ({st_reg.aw_addr[ADDR_W-1:2], 2'b00})
                OFF_CTRL: begin
                    merged = (st_reg.ctrl & ~wmask) | (st_reg.w_data & wmask);
                    st_next.ctrl[BIT_FINE] = merged[BIT_FINE];
                    st_next.ctrl[BIT_DECIMAL] = merged[BIT_DECIMAL];
                    // set wins over the self-clear
                    st_next.ctrl[BIT_INIT] = merged[BIT_INIT];
                    st_next.ctrl[BIT_ADJUST] = merged[BIT_ADJUST];
                end
                OFF_INCR: begin
                    merged = ({24'h00_0000, st_reg.incr} & ~wmask)
                             | (st_reg.w_data & wmask);
                    st_next.incr = merged[INC_W-1:0];
                end
                OFF_SEC_LOAD: begin
                    st_next.sec_load = (st_reg.sec_load & ~wmask)
                                       | (st_reg.w_data & wmask); // see R6
                end
                OFF_SUB_LOAD: begin
                    st_next.sub_load = (st_reg.sub_load & ~wmask)
                                       | (st_reg.w_data & wmask);
                end
                OFF_ADDEND: begin
                    st_next.addend = (st_reg.addend & ~wmask)
                                     | (st_reg.w_data & wmask);
                end
                OFF_SEC_NOW, OFF_SUB_NOW: begin
                    st_next.bresp = RESP_OKAY;
                end
                default: begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        do_read = s_axi_arvalid && !st_reg.rvalid;
        if (do_read) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            mapped = 1'b1;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFF_CTRL: begin
                    st_next.rdata = st_reg.ctrl;
                end
                OFF_INCR: begin
                    st_next.rdata = {24'h00_0000, st_reg.incr};
                end
                OFF_SEC_NOW: begin
                    st_next.rdata = st_reg.sec_view; // see R1
                end
                OFF_SUB_NOW: begin
                    st_next.rdata = {1'b0, st_reg.sub_view}; // see R3
                end
                OFF_SEC_LOAD: begin
                    st_next.rdata = st_reg.sec_load; // see R6
                end
                OFF_SUB_LOAD: begin
                    st_next.rdata = st_reg.sub_load;
                end
                OFF_ADDEND: begin
                    st_next.rdata = st_reg.addend;
                end
                default: begin
                    mapped = 1'b0;
                    st_next.rdata = RESET_WORD;
                end
            endcase
            if (!mapped) begin
                st_next.rresp = RESP_SLVERR;
            end
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0; // see R1
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// file: pts_regs_checker.sv
// assertion checker for the system time register block
`timescale 1ns/10ps
module pts_regs_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pts_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pts_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write response not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while stalled");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read data not released");
    a_sub_top_zero: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OFF_SUB_NOW |=> !s_axi_rdata[31])
        else $error("sub-seconds top bit set");
    a_sec_okay: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OFF_SEC_NOW |=> s_axi_rresp == RESP_OKAY)
        else $error("seconds read not okay");
endmodule
bind pts_time_regs pts_regs_checker pts_regs_checker_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// file: pts_time_regs_tb.sv
// testbench for the system time register block
`timescale 1ns/10ps
module pts_time_regs_tb;
    import pts_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] awaddr = 0;
    logic [11:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] rdata, rv, t0, ctl;
    logic [1:0] bresp, rresp, rr;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int failures = 0, num_checks = 0, cyc = 0, rc, c0;
    always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    pts_time_regs pts_time_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // response is stalled for one cycle on purpose
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
        int n;
        @(posedge aclk);
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (n == 3) bready <= 1;
        end while (!(bvalid && bready) && n < 40);
        bready <= 0;
        if (n >= 40) failures++;
        check("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(logic [11:0] a);
        int n;
        @(posedge aclk);
        n = 0;
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 0;
            if (n == 3) rready <= 1;
        end while (!(rvalid && rready) && n < 40);
        rready <= 0;
        if (n >= 40) failures++;
        rv = rdata;
        rr = rresp;
        rc = cyc;
    endtask
    initial begin
        #100_000;
        failures++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(OFF_SEC_NOW);
        check("sec reset", rv, RESET_WORD);
        rd(OFF_SUB_NOW);
        check("sub reset", rv, RESET_WORD);
        wr(OFF_SEC_LOAD, 32'h1234_5678, RESP_OKAY);
        rd(OFF_SEC_LOAD);
        check("load readback", rv, 32'h1234_5678);
        // only the lowest byte lane is written
        wstrb <= 4'h1;
        wr(OFF_SEC_LOAD, 32'hAAAA_AAAA, RESP_OKAY);
        wstrb <= 4'hF;
        rd(OFF_SEC_LOAD);
        check("load strobe", rv, 32'h1234_56AA);
        wr(OFF_SEC_NOW, 32'hFFFF_FFFF, RESP_OKAY);
        rd(OFF_SEC_NOW);
        check("sec read only", rv, RESET_WORD);
        wr(12'hFFC, 32'h0000_0001, RESP_SLVERR);
        rd(12'hFFC);
        check("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
        wr(OFF_INCR, 32'h0000_0010, RESP_OKAY);
        // binary then decimal wrap, each one step short of its limit
        for (int m = 0; m < 2; m++) begin
            ctl = m ? 32'h1 << BIT_DECIMAL : 32'h0;
            wr(OFF_SEC_LOAD, 32'h5 + m, RESP_OKAY);
            t0 = (m ? DEC_MAX : BIN_MAX) - 32'hF;
            wr(OFF_SUB_LOAD, t0, RESP_OKAY);
            wr(OFF_CTRL, ctl | 32'h1 << BIT_INIT, RESP_OKAY);
            rd(OFF_SEC_NOW);
            check("sec wrap", rv, 32'h6 + m);
            rd(OFF_SUB_NOW);
            t0 = rv;
            c0 = rc;
            check("sub wrap", {31'h0, rv < 32'h1000}, 32'h1);
            rd(OFF_SUB_NOW);
            check("sub step", rv - t0, (rc - c0) * 32'h10);
        end
        wr(OFF_SEC_LOAD, 32'h3, RESP_OKAY);
        wr(OFF_SUB_LOAD, 32'h1 << BIT_ADD_SUBTRACT_SELECT, RESP_OKAY);
        wr(OFF_CTRL, ctl | 32'h1 << BIT_ADJUST, RESP_OKAY);
        rd(OFF_SEC_NOW);
        check("sec subtract", rv, 32'h4);
        rd(OFF_CTRL);
        check("request clear", rv, ctl);
        wr(OFF_SUB_LOAD, 32'h0, RESP_OKAY);
        wr(OFF_CTRL, ctl | 32'h1 << BIT_ADJUST, RESP_OKAY);
        rd(OFF_SEC_NOW);
        check("sec add", rv, 32'h7);
        // fine mode: half-scale addend steps every second cycle
        wr(OFF_ADDEND, 32'h8000_0000, RESP_OKAY);
        wr(OFF_CTRL, ctl | 32'h1 << BIT_FINE, RESP_OKAY);
        rd(OFF_SUB_NOW);
        t0 = rv;
        c0 = rc;
        @(posedge aclk);
        rd(OFF_SUB_NOW);
        check("fine step", rv - t0, (rc - c0) / 2 * 32'h10);
        final_report();
    end
endmodule
